// [hdl/tds_pkg.sv]
// Package of constants for the transmit data link and D/E source selector
package tds_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  // Select register index; its byte address on the bus is four times it
  localparam logic [11:0] SEL_REG_IDX  = 12'h10a;
  localparam logic [11:0] SEL_REG_ADDR = {SEL_REG_IDX[9:0], 2'b00};
  localparam logic [11:0] FMT_REG_ADDR = 12'h200;
  localparam logic [11:0] STS_REG_ADDR = 12'h204;
  localparam int          BW_LSB       = 4;
  localparam int          DE_LSB       = 2;
  localparam int          DL_LSB       = 0;
  localparam logic [7:0]  SEL_RESET    = 8'h00;
  localparam logic [7:0]  SEL_WMASK    = 8'h3f;
  localparam logic [1:0]  FMT_RESET    = 2'h0;
  // ------------------------------------------------------------
  // Codes
  // ------------------------------------------------------------
  localparam logic [1:0]  BW_EVERY     = 2'h0;
  localparam logic [1:0]  BW_ODD       = 2'h1;
  localparam logic [1:0]  BW_EVEN      = 2'h2;
  localparam logic [1:0]  DE_SERIAL    = 2'h0;
  localparam logic [1:0]  DE_LAPD      = 2'h1;
  localparam logic [1:0]  DE_FRACT     = 2'h3;
  typedef enum logic [1:0]
  {
    TDS_FMT_ESF = 2'h0,
    TDS_FMT_SLC = 2'h1,
    TDS_FMT_N   = 2'h2,
    TDS_FMT_D4  = 2'h3
  } tds_fmt_e;
  typedef enum logic [2:0]
  {
    TDS_IDLE   = 3'b001,
    TDS_SETUP  = 3'b010,
    TDS_ACCESS = 3'b100
  } tds_apb_e;
endpackage : tds_pkg

// [hdl/tds_sync.sv]
// Three-stage synchroniser with agreement filter for pin inputs
module tds_sync
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin and filtered level
  input  wire logic pinIn,
  output logic      syncOut
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_syncOut;

  always_comb
  begin
    next_stage   = {stage[1:0], pinIn};
    next_syncOut = syncOut;
    // First stage feeds only the second; decision uses stages two and three
    if (stage[1] == stage[2])
    begin
      next_syncOut = stage[1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage   <= 3'h0;
      syncOut <= 1'b0;
    end
    else
    begin
      stage   <= next_stage;
      syncOut <= next_syncOut;
    end
  end
endmodule : tds_sync

// [hdl/tds_select.sv]
// Transmit data link bandwidth and D/E timeslot source selection
module tds_select
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Framer timing, same clock
  input  wire logic                  frameStart,
  input  wire logic                  deSlot,
  // Data sources
  input  wire logic                  txSerialIn,
  input  wire logic                  txFractionalIn,
  input  wire logic                  lapdBit,
  // Selections
  output logic                       linkSlot,
  output logic                       deBit,
  output logic                       deLapdTake,
  output logic [1:0]                 txLinkSource
);
  import tds_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic serSync;
  logic frtSync;

  tds_sync uSerSync
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .pinIn   (txSerialIn),
    .syncOut (serSync)
  );

  tds_sync uFrtSync
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .pinIn   (txFractionalIn),
    .syncOut (frtSync)
  );

  // ------------------------------------------------------------
  // Registers and APB slave
  // ------------------------------------------------------------
  logic [7:0]  selReg;
  logic [1:0]  fmtReg;
  logic [1:0]  frameCnt;
  tds_apb_e    apbState;
  logic [7:0]  next_selReg;
  logic [1:0]  next_fmtReg;
  tds_apb_e    next_apbState;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        hit;

  always_comb
  begin
    next_apbState = apbState;
    next_selReg   = selReg;
    next_fmtReg   = fmtReg;
    next_prdata   = prdata;
    next_pslverr  = pslverr;
    hit           = 1'b1;
    case (apbState)
      TDS_IDLE:
      begin
        if (psel && !penable)
        begin
          next_apbState = TDS_SETUP;
        end
      end
      TDS_SETUP:
      begin
        // Decode in setup so data and error are flops in the access cycle
        next_apbState = TDS_ACCESS;
        next_prdata   = 32'h0;
        if (paddr == SEL_REG_ADDR)
        begin
          next_prdata = {24'h0, selReg};
        end
        else if (paddr == FMT_REG_ADDR)
        begin
          next_prdata = {30'h0, fmtReg};
        end
        else if (paddr == STS_REG_ADDR)
        begin
          next_prdata = {28'h0, frtSync, serSync, frameCnt};
        end
        else
        begin
          hit = 1'b0;
        end
        next_pslverr = !hit;
        if (hit && pwrite)
        begin
          if (paddr == SEL_REG_ADDR)
          begin
            next_selReg = pwdata[7:0] & SEL_WMASK;
          end
          else if (paddr == FMT_REG_ADDR)
          begin
            next_fmtReg = pwdata[1:0];
          end
        end
      end
      TDS_ACCESS:
      begin
        next_pslverr = 1'b0;
        if (psel && !penable)
        begin
          next_apbState = TDS_SETUP;
        end
        else
        begin
          next_apbState = TDS_IDLE;
        end
      end
      default:
      begin
        next_apbState = TDS_IDLE;
      end
    endcase
  end

  // Write lands at the edge leaving setup, the same edge that raises pready
  assign pready = (apbState == TDS_ACCESS);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      apbState <= TDS_IDLE;
      selReg   <= SEL_RESET;
      fmtReg   <= FMT_RESET;
      prdata   <= 32'h0;
      pslverr  <= 1'b0;
    end
    else
    begin
      apbState <= next_apbState;
      selReg   <= next_selReg;
      fmtReg   <= next_fmtReg;
      prdata   <= next_prdata;
      pslverr  <= next_pslverr;
    end
  end

  // ------------------------------------------------------------
  // Link slot placement
  // ------------------------------------------------------------
  logic [1:0] bwSel;
  logic [1:0] deSel;
  logic [1:0] next_frameCnt;
  logic       next_linkSlot;
  logic       next_deBit;
  logic       next_deLapdTake;
  logic       fmtEsf;

  assign bwSel        = selReg[BW_LSB +: 2];
  assign deSel        = selReg[DE_LSB +: 2];
  assign txLinkSource = selReg[DL_LSB +: 2];
  assign fmtEsf       = (fmtReg == TDS_FMT_ESF);

  always_comb
  begin
    next_frameCnt = frameCnt;
    next_linkSlot = linkSlot;
    if (frameStart)
    begin
      // frameCnt 0 means frame 1, 5, 9; 2 means frame 3, 7, 11
      next_frameCnt = frameCnt + 2'h1;
      if (!fmtEsf)
      begin
        next_linkSlot = 1'b1;
      end
      else if (bwSel == BW_EVERY)
      begin
        next_linkSlot = 1'b1;
      end
      else if (bwSel == BW_ODD)
      begin
        next_linkSlot = (frameCnt == 2'h0);
      end
      else if (bwSel == BW_EVEN)
      begin
        next_linkSlot = (frameCnt == 2'h2);
      end
      else
      begin
        // Reserved code: no link bits rather than guessing
        next_linkSlot = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // D/E timeslot source
  // ------------------------------------------------------------
  always_comb
  begin
    next_deBit      = 1'b0;
    next_deLapdTake = 1'b0;
    if (deSlot)
    begin
      if (deSel == DE_SERIAL)
      begin
        next_deBit = serSync;
      end
      else if (deSel == DE_LAPD)
      begin
        next_deBit      = lapdBit;
        next_deLapdTake = 1'b1;
      end
      else if (deSel == DE_FRACT)
      begin
        next_deBit = frtSync;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      frameCnt   <= 2'h0;
      linkSlot   <= 1'b0;
      deBit      <= 1'b0;
      deLapdTake <= 1'b0;
    end
    else
    begin
      frameCnt   <= next_frameCnt;
      linkSlot   <= next_linkSlot;
      deBit      <= next_deBit;
      deLapdTake <= next_deLapdTake;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  every_frame_a: assert property (@(posedge clk) disable iff (!rst_n)
    frameStart && fmtEsf && bwSel == BW_EVERY |=> linkSlot)
    else $error("link slot missing in every-frame mode");

  odd_frames_a: assert property (@(posedge clk) disable iff (!rst_n)
    frameStart && fmtEsf && bwSel == BW_ODD
      |=> linkSlot == ($past(frameCnt) == 2'h0))
    else $error("odd framing position placement wrong");

  even_frames_a: assert property (@(posedge clk) disable iff (!rst_n)
    frameStart && fmtEsf && bwSel == BW_EVEN
      |=> linkSlot == ($past(frameCnt) == 2'h2))
    else $error("even framing position placement wrong");

  non_esf_a: assert property (@(posedge clk) disable iff (!rst_n)
    frameStart && !fmtEsf |=> linkSlot)
    else $error("bandwidth code used outside extended superframe");

  slot_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !frameStart |=> $stable(linkSlot))
    else $error("link slot changed without a frame start");

  de_serial_a: assert property (@(posedge clk) disable iff (!rst_n)
    deSlot && deSel == DE_SERIAL |=> deBit == $past(serSync))
    else $error("serial source not used for D/E slot");

  de_lapd_a: assert property (@(posedge clk) disable iff (!rst_n)
    deSlot && deSel == DE_LAPD |=> deLapdTake && deBit == $past(lapdBit))
    else $error("LAPD source not used for D/E slot");

  de_fract_a: assert property (@(posedge clk) disable iff (!rst_n)
    deSlot && deSel == DE_FRACT |=> !deLapdTake && deBit == $past(frtSync))
    else $error("fractional source not used for D/E slot");

  de_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !deSlot |=> !deBit && !deLapdTake)
    else $error("D/E output active outside a D/E slot");

  de_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    deSlot && deSel == 2'h2 |=> !deBit && !deLapdTake)
    else $error("reserved D/E source code produced data");

  bw_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    frameStart && fmtEsf && bwSel == 2'h3 |=> !linkSlot)
    else $error("link slot placed under reserved bandwidth code");

  frame_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    frameStart |=> frameCnt == $past(frameCnt) + 2'h1)
    else $error("framing position counter did not advance");
endmodule : tds_select

// [tb/tds_term_model.sv]
// Terminal equipment model driving the serial and fractional input pins
module tds_term_model
(
  // Clock
  input  wire logic clk,
  // Levels requested by the bench
  input  wire logic serLvl,
  input  wire logic frLvl,
  // Pins into the block
  output logic      txSerialIn,
  output logic      txFractionalIn
);
  timeunit 1ns;
  timeprecision 100ps;
  initial txSerialIn = 1'b0;
  initial txFractionalIn = 1'b0;
  // Levels change only on an edge; held long enough for the pin filter
  always @(posedge clk)
  begin
    txSerialIn <= serLvl;
    txFractionalIn <= frLvl;
  end
endmodule : tds_term_model

// [tb/tb_tds_select.sv]
// Testbench for the link bandwidth and D/E source selector
`define CHK(g, e) chk(g, e);
module tb_tds_select;
  timeunit 1ns;
  timeprecision 100ps;
  import tds_pkg::*;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, frameStart = 0, deSlot = 0, lapdBit = 0;
  logic        serLvl = 0, frLvl = 0, txSerialIn, txFractionalIn;
  logic        linkSlot, deBit, deLapdTake;
  logic [1:0]  txLinkSource;
  int          errTotal = 0, numChecks = 0;
  initial forever #4 clk = ~clk;
  tds_select tds_select_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frameStart(frameStart), .deSlot(deSlot), .txSerialIn(txSerialIn),
    .txFractionalIn(txFractionalIn), .lapdBit(lapdBit),
    .linkSlot(linkSlot), .deBit(deBit), .deLapdTake(deLapdTake),
    .txLinkSource(txLinkSource));
  tds_term_model tds_term_model_inst (.clk(clk), .serLvl(serLvl),
    .frLvl(frLvl), .txSerialIn(txSerialIn),
    .txFractionalIn(txFractionalIn));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task giveVerdict;
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : giveVerdict
  task chk(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e)
    begin
      errTotal++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task rstDut;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : rstDut
  // Read data is taken at the rising edge where pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      errTotal++;
      giveVerdict();
    end
    // One idle edge so the next call never reassigns psel in this step
    @(posedge clk);
  endtask : apb
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic regs;
    logic [31:0] rd;
    logic        e;
    apb(1'b0, SEL_REG_ADDR, 32'h0, rd, e);
    `CHK(rd, {24'h0, SEL_RESET})
    `CHK(e, 1'b0)
    apb(1'b0, STS_REG_ADDR, 32'h0, rd, e);
    `CHK(rd, 32'h0)
    apb(1'b0, FMT_REG_ADDR, 32'h0, rd, e);
    `CHK(rd, {30'h0, FMT_RESET})
    apb(1'b1, SEL_REG_ADDR, 32'hff, rd, e);
    `CHK(txLinkSource, 2'h3)
    apb(1'b0, SEL_REG_ADDR, 32'h0, rd, e);
    `CHK(rd, {24'h0, SEL_WMASK})
    apb(1'b0, 12'h0fc, 32'h0, rd, e);
    `CHK(e, 1'b1)
  endtask : regs
  // Eight frames from reset: bit i of exp is frame i+1 of the cycle
  task automatic frames(input logic [1:0] fmt, input logic [1:0] bw,
                        input logic [3:0] exp);
    logic [31:0] rd;
    logic        e;
    rstDut();
    apb(1'b1, FMT_REG_ADDR, {30'h0, fmt}, rd, e);
    apb(1'b1, SEL_REG_ADDR, {26'h0, bw, 4'h0}, rd, e);
    for (int i = 0; i < 8; i++)
    begin
      frameStart <= 1'b1;
      @(posedge clk);
      frameStart <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(linkSlot, exp[i % 4])
    end
  endtask : frames
  // src holds {lapd, fractional, serial} levels
  task automatic deCase(input logic [1:0] code, input logic [2:0] src,
                        input logic exp, input logic take);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, SEL_REG_ADDR, {28'h0, code, 2'h0}, rd, e);
    serLvl <= src[0];
    frLvl <= src[1];
    lapdBit <= src[2];
    repeat (8) @(posedge clk);
    deSlot <= 1'b1;
    @(posedge clk);
    deSlot <= 1'b0;
    @(negedge clk);
    `CHK({deBit, deLapdTake}, {exp, take})
    @(negedge clk);
    `CHK(deBit, 1'b0)
    @(posedge clk);
  endtask : deCase
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    rstDut();
    regs();
    frames(TDS_FMT_ESF, BW_EVERY, 4'hf);
    frames(TDS_FMT_ESF, BW_ODD, 4'h1);
    frames(TDS_FMT_ESF, BW_EVEN, 4'h4);
    frames(TDS_FMT_ESF, 2'h3, 4'h0);
    frames(TDS_FMT_SLC, BW_ODD, 4'hf);
    frames(TDS_FMT_N, BW_EVEN, 4'hf);
    deCase(DE_SERIAL, 3'b001, 1'b1, 1'b0);
    deCase(DE_SERIAL, 3'b110, 1'b0, 1'b0);
    deCase(DE_LAPD, 3'b100, 1'b1, 1'b1);
    deCase(DE_LAPD, 3'b011, 1'b0, 1'b1);
    deCase(DE_FRACT, 3'b010, 1'b1, 1'b0);
    deCase(DE_FRACT, 3'b101, 1'b0, 1'b0);
    deCase(2'h2, 3'b111, 1'b0, 1'b0);
    giveVerdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errTotal++;
    giveVerdict();
  end
endmodule : tb_tds_select
